// [design/dtm_top.sv]
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module dtm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_in_a,
  input  wire logic        event_in_b,
  output logic             toggle_out_a,
  output logic             toggle_out_a_oe,
  output logic             toggle_out_b,
  output logic             toggle_out_b_oe,
  output logic             match_irq_a,
  output logic             match_irq_b
);
  typedef struct packed {
    logic [7:0]  clk_sel;
    logic [7:0]  mode;
    logic [7:0]  outc;
    logic [7:0]  dir;
    logic [7:0]  latch;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [11:0] pre;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic        lv_a;
    logic        lv_b;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq_a;
    logic        irq_b;
    logic        pin_a;
    logic        pin_b;
    logic        oe_a;
    logic        oe_b;
  } dtm_st_t;

  dtm_st_t st_r;
  dtm_st_t st_nxt;

  dtm_chan_if ch_a ();
  dtm_chan_if ch_b ();

  dtm_chan u_chan_a (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_a.cnt)
  );

  dtm_chan u_chan_b (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_b.cnt)
  );

  // Tick source for one counter from its 4-bit select code
  function automatic logic sel_tick(
    input logic [3:0]  code,
    input logic [11:0] pre,
    input logic        rise,
    input logic        fall
  );
    logic [11:0] mask;
    int          n;
    mask = 12'h000;
    n    = 0;
    if (code == dtm_pkg::SEL_FALL)
      sel_tick = fall;
    else if (code == dtm_pkg::SEL_RISE)
      sel_tick = rise;
    else if (code >= dtm_pkg::SEL_DIV_LO && code <= dtm_pkg::SEL_DIV_HI)
    begin
      n        = int'(code - dtm_pkg::SEL_DIV_BIAS);
      mask     = 12'((13'h1 << n) - 13'h1);
      sel_tick = ((pre & mask) == mask);
    end
    else if (code == dtm_pkg::SEL_DIV4096)
      sel_tick = (pre == 12'hfff);
    else
      sel_tick = 1'b0;
  endfunction

  logic       rise_a;
  logic       fall_a;
  logic       rise_b;
  logic       fall_b;
  logic       tick_a;
  logic       tick_b;
  logic       cascade;
  logic       full_match;
  logic       wr_en;
  logic       rd_cyc;
  logic [3:0] code_a;
  logic [3:0] code_b;

  // Edge pulses from second and third sync stages
  assign rise_a = st_r.sync_a[1] & ~st_r.sync_a[2];
  assign fall_a = ~st_r.sync_a[1] & st_r.sync_a[2];
  assign rise_b = st_r.sync_b[1] & ~st_r.sync_b[2];
  assign fall_b = ~st_r.sync_b[1] & st_r.sync_b[2];

  assign code_a  = st_r.clk_sel[dtm_pkg::SEL_A_LSB +: 4];
  assign code_b  = st_r.clk_sel[dtm_pkg::SEL_B_LSB +: 4];
  assign tick_a  = sel_tick(code_a, st_r.pre, rise_a, fall_a);
  assign tick_b  = sel_tick(code_b, st_r.pre, rise_b, fall_b);
  assign cascade = st_r.mode[dtm_pkg::MODE_CASCADE];

  // Sixteen-bit match: A hits while B already equals its compare
  assign full_match = ch_a.hit && ch_b.equal;

  // Channel steering
  assign ch_a.tick      = tick_a;
  assign ch_a.run       = st_r.mode[dtm_pkg::MODE_EN_A];
  assign ch_a.cmp       = st_r.cmp_a;
  assign ch_a.use_match = ~cascade;
  assign ch_a.force_clr = cascade && full_match;

  assign ch_b.tick      = cascade ? (ch_a.wrap || full_match) : tick_b;
  assign ch_b.run       = cascade ? st_r.mode[dtm_pkg::MODE_EN_A]
                                  : st_r.mode[dtm_pkg::MODE_EN_B];
  assign ch_b.cmp       = st_r.cmp_b;
  assign ch_b.use_match = ~cascade;
  assign ch_b.force_clr = cascade && full_match;

  // Write lands only at the edge where pready is seen high
  assign wr_en  = psel && penable && pwrite && st_r.pready;
  assign rd_cyc = psel && penable && !st_r.pready;

  always_comb
  begin
    st_nxt = st_r;

    // Free-running prescaler on the main clock
    st_nxt.pre = st_r.pre + 12'h001;

    // Two-flop synchronisers plus edge-history stage
    st_nxt.sync_a = {st_r.sync_a[1:0], event_in_a};
    st_nxt.sync_b = {st_r.sync_b[1:0], event_in_b};

    // Match requests, one cycle each
    st_nxt.irq_a = ch_a.hit;
    st_nxt.irq_b = cascade ? full_match : ch_b.hit;

    // Level flip-flops invert on match when enabled
    if (st_r.outc[dtm_pkg::OUT_INV_A] && ch_a.hit)
      st_nxt.lv_a = ~st_r.lv_a;
    if (st_r.outc[dtm_pkg::OUT_INV_B] && (cascade ? full_match : ch_b.hit))
      st_nxt.lv_b = ~st_r.lv_b;

    // APB access: one wait cycle, then pready for one cycle
    st_nxt.pready  = rd_cyc;
    st_nxt.pslverr = 1'b0;
    if (rd_cyc)
    begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        dtm_pkg::ADDR_CLK_SEL: st_nxt.prdata[7:0] = st_r.clk_sel;
        dtm_pkg::ADDR_MODE:    st_nxt.prdata[7:0] = st_r.mode;
        dtm_pkg::ADDR_OUT:     st_nxt.prdata[7:0] = st_r.outc;
        dtm_pkg::ADDR_DIR:     st_nxt.prdata[7:0] = st_r.dir;
        dtm_pkg::ADDR_CMP_A:   st_nxt.prdata[7:0] = st_r.cmp_a;
        dtm_pkg::ADDR_CMP_B:   st_nxt.prdata[7:0] = st_r.cmp_b;
        dtm_pkg::ADDR_CNT_A:   st_nxt.prdata[7:0] = ch_a.count;
        dtm_pkg::ADDR_CNT_B:   st_nxt.prdata[7:0] = ch_b.count;
        dtm_pkg::ADDR_LATCH:   st_nxt.prdata[7:0] = st_r.latch;
        default:               st_nxt.pslverr     = 1'b1;
      endcase
    end

    if (wr_en)
    begin
      case (paddr)
        dtm_pkg::ADDR_CLK_SEL: st_nxt.clk_sel = pwdata[7:0];
        dtm_pkg::ADDR_MODE:    st_nxt.mode    = pwdata[7:0];
        dtm_pkg::ADDR_OUT:
        begin
          st_nxt.outc = pwdata[7:0] & ~dtm_pkg::OUT_CMD_MASK;
          if (pwdata[dtm_pkg::OUT_LVR_A])
            st_nxt.lv_a = 1'b0;
          if (pwdata[dtm_pkg::OUT_LVS_A])
            st_nxt.lv_a = 1'b1;
          if (pwdata[dtm_pkg::OUT_LVR_B])
            st_nxt.lv_b = 1'b0;
          if (pwdata[dtm_pkg::OUT_LVS_B])
            st_nxt.lv_b = 1'b1;
        end
        dtm_pkg::ADDR_DIR:     st_nxt.dir    = pwdata[7:0];
        dtm_pkg::ADDR_CMP_A:   st_nxt.cmp_a  = pwdata[7:0];
        dtm_pkg::ADDR_CMP_B:   st_nxt.cmp_b  = pwdata[7:0];
        dtm_pkg::ADDR_LATCH:   st_nxt.latch  = pwdata[7:0];
        default:               st_nxt.latch  = st_r.latch;
      endcase
    end

    // Pin drive: latch ORed with gated level, enabled by direction bit
    st_nxt.pin_a = st_r.latch[dtm_pkg::PIN_A] |
                   (st_r.outc[dtm_pkg::OUT_TOE_A] & st_r.lv_a);
    st_nxt.pin_b = st_r.latch[dtm_pkg::PIN_B] |
                   (st_r.outc[dtm_pkg::OUT_TOE_B] & st_r.lv_b);
    st_nxt.oe_a  = ~st_r.dir[dtm_pkg::PIN_A];
    st_nxt.oe_b  = ~st_r.dir[dtm_pkg::PIN_B];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r         <= '0;
      st_r.clk_sel <= dtm_pkg::RST_CLK_SEL;
      st_r.mode    <= dtm_pkg::RST_MODE;
      st_r.outc    <= dtm_pkg::RST_OUT;
      st_r.dir     <= dtm_pkg::RST_DIR;
      st_r.latch   <= dtm_pkg::RST_LATCH;
      st_r.cmp_a   <= dtm_pkg::RST_CMP;
      st_r.cmp_b   <= dtm_pkg::RST_CMP;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign toggle_out_a    = st_r.pin_a;
  assign toggle_out_a_oe = st_r.oe_a;
  assign toggle_out_b    = st_r.pin_b;
  assign toggle_out_b_oe = st_r.oe_b;
  assign match_irq_a     = st_r.irq_a;
  assign match_irq_b     = st_r.irq_b;
endmodule

// [design/dtm_pkg.sv]
package dtm_pkg;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h04;
  localparam logic [7:0] ADDR_OUT     = 8'h08;
  localparam logic [7:0] ADDR_DIR     = 8'h0c;
  localparam logic [7:0] ADDR_CMP_A   = 8'h10;
  localparam logic [7:0] ADDR_CMP_B   = 8'h14;
  localparam logic [7:0] ADDR_CNT_A   = 8'h18;
  localparam logic [7:0] ADDR_CNT_B   = 8'h1c;
  localparam logic [7:0] ADDR_LATCH   = 8'h20;

  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_OUT     = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'hff;
  localparam logic [7:0] RST_LATCH   = 8'h00;
  localparam logic [7:0] RST_CMP     = 8'h00;
  localparam logic [7:0] RST_CNT     = 8'h00;

  // Mode control bits
  localparam int MODE_EN_A    = 0;
  localparam int MODE_EN_B    = 1;
  localparam int MODE_CASCADE = 2;

  // Output control bits
  localparam int OUT_TOE_A = 0;
  localparam int OUT_INV_A = 1;
  localparam int OUT_LVR_A = 2;
  localparam int OUT_LVS_A = 3;
  localparam int OUT_TOE_B = 4;
  localparam int OUT_INV_B = 5;
  localparam int OUT_LVR_B = 6;
  localparam int OUT_LVS_B = 7;
  localparam logic [7:0] OUT_CMD_MASK = 8'hcc;

  // Port-3 pins carrying the toggle outputs
  localparam int PIN_A = 1;
  localparam int PIN_B = 2;

  // Clock select field layout and codes
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 4;
  localparam logic [3:0] SEL_FALL     = 4'h0;
  localparam logic [3:0] SEL_RISE     = 4'h1;
  localparam logic [3:0] SEL_DIV_LO   = 4'h5;
  localparam logic [3:0] SEL_DIV_HI   = 4'he;
  localparam logic [3:0] SEL_DIV4096  = 4'hf;
  localparam logic [3:0] SEL_DIV_BIAS = 4'h4;
  localparam int         DIV4096_LOG  = 12;
  localparam int         PRE_W        = 12;
endpackage

// [design/dtm_chan_if.sv]
`timescale 1ns/1ps
interface dtm_chan_if;
  logic       tick;
  logic       run;
  logic [7:0] cmp;
  logic       use_match;
  logic       force_clr;
  logic [7:0] count;
  logic       hit;
  logic       wrap;
  logic       equal;

  modport ctl (output tick, output run, output cmp, output use_match, output force_clr,
               input count, input hit, input wrap, input equal);
  modport cnt (input tick, input run, input cmp, input use_match, input force_clr,
               output count, output hit, output wrap, output equal);
endinterface

// [design/dtm_chan.sv]
`timescale 1ns/1ps
module dtm_chan (
  input  wire logic pclk,
  input  wire logic presetn,
  dtm_chan_if.cnt   ch
);
  typedef struct packed {
    logic [7:0] count;
  } dtm_cst_t;

  dtm_cst_t st_r;
  dtm_cst_t st_nxt;

  assign ch.count = st_r.count;
  assign ch.equal = (st_r.count == ch.cmp);
  assign ch.hit   = ch.equal && ch.tick && ch.run;
  assign ch.wrap  = (st_r.count == 8'hff) && ch.tick && ch.run;

  always_comb
  begin
    st_nxt = st_r;
    if (ch.run && ch.tick)
    begin
      if (ch.force_clr || (ch.use_match && ch.hit))
        st_nxt.count = dtm_pkg::RST_CNT;
      else
        st_nxt.count = st_r.count + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// [test/dtm_properties.sv]
`timescale 1ns/1ps
module dtm_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        toggle_out_a_oe,
  input wire logic        match_irq_a,
  input wire logic        match_irq_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wdone = pready && pwrite;
  a_ready_follow: assert property (psel && penable && !pready |=> pready)
    else $error("No pready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_read: assert property (pslverr |-> pready && !pwrite)
    else $error("pslverr outside a read answer");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("Upper read data not zero");
  a_cmd_zero: assert property (pready && !pwrite && paddr == dtm_pkg::ADDR_OUT
    |-> (prdata[7:0] & dtm_pkg::OUT_CMD_MASK) == 8'h00) else $error("Command bits read one");
  a_oe_by_write: assert property ($changed(toggle_out_a_oe)
    |-> $past(wdone) || $past(wdone, 2)) else $error("Pin enable moved without write");
  a_irq_a_pulse: assert property (match_irq_a |=> !match_irq_a)
    else $error("Match request A too long");
  a_irq_b_pulse: assert property (match_irq_b |=> !match_irq_b)
    else $error("Match request B too long");
endmodule
bind dtm_top dtm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .toggle_out_a_oe(toggle_out_a_oe), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));

// [test/dtm_pulse_src.sv]
`timescale 1ns/1ps
module dtm_pulse_src (
  input  wire logic pclk,
  output logic      ev_a,
  output logic      ev_b
);
  initial
  begin
    ev_a = 1'b0;
    ev_b = 1'b0;
  end
  // Each level held 2 to 5 clocks, line idles low
  task automatic pulses(input int ch, input int n);
    repeat (2 * n)
    begin
      if (ch == 0) ev_a <= ~ev_a;
      else ev_b <= ~ev_b;
      repeat ($urandom_range(2, 5)) @(posedge pclk);
    end
  endtask
  // Single level change, then a settle gap
  task automatic step(input int ch);
    if (ch == 0)
      ev_a <= ~ev_a;
    else
      ev_b <= ~ev_b;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ev_a, ev_b, to_a, oe_a, to_b, oe_b, irq_a, irq_b;
  int          bad_count, checks_done;
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  dtm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in_a(ev_a), .event_in_b(ev_b), .toggle_out_a(to_a),
    .toggle_out_a_oe(oe_a), .toggle_out_b(to_b), .toggle_out_b_oe(oe_b),
    .match_irq_a(irq_a), .match_irq_b(irq_b));
  dtm_pulse_src u_src (.pclk(pclk), .ev_a(ev_a), .ev_b(ev_b));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] q, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      bad_count++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rc(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk("register", q, {24'h0, x});
  endtask
  // Cycles until the next match request of a channel
  task wirq(input int ch, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((ch ? irq_b : irq_a) !== 1'b1 && n < 20000);
    if (n >= 20000)
    begin
      bad_count++;
      close_out();
    end
  endtask
  function automatic int per(int c, int cm);
    return (cm + 1) << (c == 15 ? 12 : c - 4);
  endfunction
  initial
  begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    close_out();
  end
  initial
  begin
    logic [31:0] q;
    logic        e, t;
    int          n, p, c, ch, cm;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    checks_done = 0;
    void'($urandom(32'h69074598));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(dtm_pkg::ADDR_CLK_SEL, 8'h00);
    rc(dtm_pkg::ADDR_MODE, 8'h00);
    rc(dtm_pkg::ADDR_OUT, 8'h00);
    rc(dtm_pkg::ADDR_DIR, 8'hff);
    rc(dtm_pkg::ADDR_CNT_A, 8'h00);
    chk("pin enable", {31'h0, oe_a}, 32'h0);
    apb(1'b0, 8'h24, 8'h00, q, e);
    chk("error", {31'h0, e}, 32'h1);
    chk("unmapped", q, 32'h0);
    c = $urandom_range(0, 255);
    wr(dtm_pkg::ADDR_OUT, c[7:0]);
    rc(dtm_pkg::ADDR_OUT, c[7:0] & ~dtm_pkg::OUT_CMD_MASK);
    wr(dtm_pkg::ADDR_DIR, 8'hf9);
    repeat (2) @(posedge pclk);
    chk("pin enable", {30'h0, oe_b, oe_a}, 32'h3);
    wr(dtm_pkg::ADDR_OUT, 8'h09);
    repeat (3) @(posedge pclk);
    chk("pin a", {31'h0, to_a}, 32'h1);
    wr(dtm_pkg::ADDR_OUT, 8'h05);
    repeat (3) @(posedge pclk);
    chk("pin a", {31'h0, to_a}, 32'h0);
    wr(dtm_pkg::ADDR_OUT, 8'h33);
    for (c = 5; c < 16; c++)
    begin
      ch = c % 2;
      cm = $urandom_range(1, 2);
      wr(dtm_pkg::ADDR_MODE, 8'h00);
      wr(dtm_pkg::ADDR_CLK_SEL, ch ? {c[3:0], 4'h0} : {4'h0, c[3:0]});
      wr(ch ? dtm_pkg::ADDR_CMP_B : dtm_pkg::ADDR_CMP_A, cm[7:0]);
      wr(dtm_pkg::ADDR_MODE, ch ? 8'h02 : 8'h01);
      wirq(ch, n);
      @(posedge pclk);
      t = ch ? to_b : to_a;
      wirq(ch, p);
      chk("interval", p + 1, per(c, cm));
      @(posedge pclk);
      chk("pin", {31'h0, ch ? to_b : to_a}, {31'h0, ~t});
    end
    wr(dtm_pkg::ADDR_MODE, 8'h00);
    apb(1'b0, dtm_pkg::ADDR_CNT_A, 8'h00, q, e);
    repeat (40) @(posedge pclk);
    rc(dtm_pkg::ADDR_CNT_A, q[7:0]);
    wr(dtm_pkg::ADDR_CLK_SEL, 8'h22);
    wr(dtm_pkg::ADDR_MODE, 8'h03);
    repeat (40) @(posedge pclk);
    rc(dtm_pkg::ADDR_CNT_A, q[7:0]);
    for (c = 0; c < 4; c++)
    begin
      ch = c / 2;
      wr(dtm_pkg::ADDR_MODE, 8'h00);
      wr(dtm_pkg::ADDR_CLK_SEL, {3'h0, c[0], 3'h0, c[0]});
      wr(ch ? dtm_pkg::ADDR_CMP_B : dtm_pkg::ADDR_CMP_A, 8'hff);
      apb(1'b0, ch ? dtm_pkg::ADDR_CNT_B : dtm_pkg::ADDR_CNT_A, 8'h00, q, e);
      wr(dtm_pkg::ADDR_MODE, 8'h03);
      n = $urandom_range(1, 20);
      u_src.pulses(ch, n);
      repeat (6) @(posedge pclk);
      rc(ch ? dtm_pkg::ADDR_CNT_B : dtm_pkg::ADDR_CNT_A, q[7:0] + n[7:0]);
      u_src.step(ch);
      rc(ch ? dtm_pkg::ADDR_CNT_B : dtm_pkg::ADDR_CNT_A, q[7:0] + n[7:0] + {7'h0, c[0]});
      u_src.step(ch);
    end
    // Compare zero: both counters settle at zero
    wr(dtm_pkg::ADDR_MODE, 8'h00);
    wr(dtm_pkg::ADDR_CLK_SEL, 8'h55);
    wr(dtm_pkg::ADDR_CMP_A, 8'h00);
    wr(dtm_pkg::ADDR_CMP_B, 8'h00);
    wr(dtm_pkg::ADDR_MODE, 8'h03);
    wirq(1, n);
    wirq(0, n);
    @(posedge pclk);
    wirq(0, p);
    chk("interval", p + 1, per(5, 0));
    wr(dtm_pkg::ADDR_MODE, 8'h00);
    rc(dtm_pkg::ADDR_CNT_B, 8'h00);
    // Cascade run from zero, started by enable A alone
    cm = $urandom_range(0, 255);
    wr(dtm_pkg::ADDR_CMP_A, cm[7:0]);
    wr(dtm_pkg::ADDR_CMP_B, 8'h01);
    wr(dtm_pkg::ADDR_MODE, 8'h05);
    wirq(1, n);
    @(posedge pclk);
    wirq(1, p);
    chk("cascade", p + 1, per(5, 256 + cm));
    wr(dtm_pkg::ADDR_MODE, 8'h04);
    apb(1'b0, dtm_pkg::ADDR_CNT_A, 8'h00, q, e);
    repeat (20) @(posedge pclk);
    rc(dtm_pkg::ADDR_CNT_A, q[7:0]);
    // Reset with both counters stopped
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("pin enable", {30'h0, oe_b, oe_a}, 32'h0);
    presetn <= 1'b1;
    rc(dtm_pkg::ADDR_MODE, 8'h00);
    rc(dtm_pkg::ADDR_OUT, 8'h00);
    rc(dtm_pkg::ADDR_DIR, 8'hff);
    rc(dtm_pkg::ADDR_CNT_B, 8'h00);
    close_out();
  end
endmodule
